// ---- verilog/adc_ctrl_pkg.sv ----
// Constants, register map, types and shared decode for the converter control block
package adc_ctrl_pkg;

	localparam int RES_W    = 10;
	localparam int SEQ_N    = 4;
	localparam int STEP_MAX = 8;
	localparam int ACC_W    = 16;

	localparam logic [11:0] OFS_ACTIVE   = 12'h000;
	localparam logic [11:0] OFS_RIS      = 12'h004;
	localparam logic [11:0] OFS_IM       = 12'h008;
	localparam logic [11:0] OFS_ISC      = 12'h00C;
	localparam logic [11:0] OFS_OSTAT    = 12'h010;
	localparam logic [11:0] OFS_EMUX     = 12'h014;
	localparam logic [11:0] OFS_USTAT    = 12'h018;
	localparam logic [11:0] OFS_PRI      = 12'h020;
	localparam logic [11:0] OFS_PSSI     = 12'h028;
	localparam logic [11:0] OFS_SAC      = 12'h030;
	localparam logic [11:0] OFS_LOOP     = 12'h100;
	localparam logic [11:0] OFS_SEQ_BASE = 12'h040;
	localparam logic [11:0] OFS_SEQ_LAST = 12'h0AF;
	localparam logic [4:0]  SUB_MUX      = 5'h00;
	localparam logic [4:0]  SUB_CTL      = 5'h04;
	localparam logic [4:0]  SUB_FIFO     = 5'h08;
	localparam logic [4:0]  SUB_FSTAT    = 5'h0C;

	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [15:0] RST_PRI  = 16'h3210;
	localparam logic [31:0] RST_CTL3 = 32'h0000_0002;

	// Step control nibble bits
	localparam int CTL_DIFF = 0;
	localparam int CTL_LAST = 1;
	localparam int CTL_IE   = 2;
	localparam int CTL_TEMP = 3;

	localparam logic [2:0] AVG_MAX_LOG = 3'h6;
	localparam logic [3:0] TRIG_PROC   = 4'h0;
	localparam logic [3:0] TRIG_ALWAYS = 4'hF;

	localparam int FSTAT_HEAD_LSB = 4;
	localparam int FSTAT_EMPTY    = 8;
	localparam int FSTAT_FULL     = 12;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_WAIT  = 2'b10,
		ST_STORE = 2'b11
	} seq_state_type;

	function automatic logic [3:0] nib(input logic [31:0] w, input logic [2:0] i);
		nib = w[{i, 2'b00} +: 4];
	endfunction

	// FIFO depth equals step count per sequencer: 8, 4, 4, 1
	function automatic logic [3:0] seq_depth(input logic [1:0] s);
		case (s)
			2'h0:    seq_depth = 4'h8;
			2'h1:    seq_depth = 4'h4;
			2'h2:    seq_depth = 4'h4;
			default: seq_depth = 4'h1;
		endcase
	endfunction

endpackage

// ---- verilog/adc_ctrl.sv ----
// Converter control: sequencers, averaging, differential steps, loopback, AHB-Lite registers
//
// What this block does
// - Average up to 64 conversions per FIFO entry
// - Averaging count conversions for each stored result
// - Averaging off after reset, results pass unchanged
// - One averaging setting for all steps
// - Each conversion gives a 10-bit unsigned code
// - Step differential only when its select bit set
// - Differential pair k uses inputs 2k, 2k+1
// - Only fixed adjacent even/odd pairs supported
// - Differential zero difference reads 0x1FF
// - Even input positive, odd input negative
// - Digital loopback mode needs no analog stimulus
// - Priority resets to 0 highest, 3 lowest
// - Disabled sequencer programmable, ignores triggers
// - Enable bit makes sequencer answer its trigger
// - FIFO word holds result in low 10 bits
// - Each step has input and control nibbles
// - Writing 1 to status-clear bit clears it
`timescale 1ns/10ps
module adc_ctrl
	import adc_ctrl_pkg::*;
(
	input  wire logic              clk_i,          // 20 MHz clock
	input  wire logic              reset_n_i,      // Synchronous reset, active low
	input  wire logic              hsel_i,         // AHB slave select
	input  wire logic [31:0]       haddr_i,        // AHB address
	input  wire logic [1:0]        htrans_i,       // AHB transfer type
	input  wire logic              hwrite_i,       // AHB write
	input  wire logic [2:0]        hsize_i,        // AHB size, word only
	input  wire logic [31:0]       hwdata_i,       // AHB write data
	input  wire logic              hready_i,       // AHB bus ready
	output logic      [31:0]       hrdata_o,       // AHB read data
	output logic                   hreadyout_o,    // AHB slave ready
	output logic                   hresp_o,        // AHB response, always OKAY
	input  wire logic              ext_trigger_i,  // External trigger pin
	input  wire logic              conv_done_i,    // Converter result ready, level toggling
	input  wire logic [RES_W-1:0]  conv_data_i,    // Converter result code
	output logic                   conv_start_o,   // Start one conversion, pulse
	output logic      [2:0]        conv_channel_o, // Input, or even input of a pair
	output logic                   conv_diff_o,    // Differential conversion
	output logic                   conv_temp_o,    // Temperature sensor input
	output logic                   irq_o           // Masked sequencer interrupt
);

	seq_state_type          state_q;
	logic [3:0]             active_q, ris_q, im_q, ostat_q, ustat_q, pend_q;
	logic [15:0]            emux_q, pri_q;
	logic [2:0]             sac_q;
	logic                   loop_q;
	logic [31:0]            mux_q [SEQ_N];
	logic [31:0]            ctl_q [SEQ_N];
	logic [RES_W-1:0]       fifo_q [SEQ_N][STEP_MAX];
	logic [2:0]             head_q [SEQ_N];
	logic [2:0]             tail_q [SEQ_N];
	logic [3:0]             cnt_q [SEQ_N];
	logic                   wr_q, rd_q, hready_q;
	logic [11:0]            addr_q;
	logic [31:0]            hrdata_q;
	logic                   done_meta_q, done_sync_q, done_prev_q;
	logic [RES_W-1:0]       data_meta_q, data_sync_q;
	logic                   ext_meta_q, ext_sync_q, ext_prev_q;
	logic [1:0]             cur_q;
	logic [2:0]             step_q;
	logic [6:0]             rep_q, loop_cnt_q;
	logic [ACC_W-1:0]       acc_q;
	logic                   start_q, diff_q, temp_q, irq_q;
	logic [2:0]             chan_q;

	// Bus decode
	wire              addr_take = hsel_i & hready_i & htrans_i[1];
	wire [11:0]       addr_rel  = addr_q - OFS_SEQ_BASE;
	wire              seq_hit   = (addr_q >= OFS_SEQ_BASE) && (addr_q <= OFS_SEQ_LAST);
	wire [1:0]        a_seq     = addr_rel[6:5];
	wire [4:0]        a_sub     = addr_rel[4:0];
	wire              wr_isc    = wr_q && (addr_q == OFS_ISC);
	wire              wr_ostat  = wr_q && (addr_q == OFS_OSTAT);
	wire              wr_ustat  = wr_q && (addr_q == OFS_USTAT);
	wire [3:0]        pssi_set  = (wr_q && (addr_q == OFS_PSSI)) ? hwdata_i[3:0] : 4'h0;
	wire              pop_req   = rd_q && seq_hit && (a_sub == SUB_FIFO);

	// Sequencer datapath
	wire [3:0]        cur_mux   = nib(mux_q[cur_q], step_q);
	wire [3:0]        cur_ctl   = nib(ctl_q[cur_q], step_q);
	wire [2:0]        avg_log   = (sac_q > AVG_MAX_LOG) ? AVG_MAX_LOG : sac_q;
	wire [6:0]        rep_last  = 7'((8'h01 << avg_log) - 8'h01);
	wire [RES_W-1:0]  loop_val  = {loop_cnt_q, step_q};
	wire [RES_W-1:0]  sample    = loop_q ? loop_val : data_sync_q;
	wire              conv_ev   = (state_q == ST_WAIT) && (loop_q || (done_sync_q ^ done_prev_q));
	wire [ACC_W-1:0]  acc_sum   = acc_q + ACC_W'(sample);
	wire [ACC_W-1:0]  avg_full  = acc_q >> avg_log;
	wire [RES_W-1:0]  avg_res   = avg_full[RES_W-1:0];
	wire              ext_rise  = ext_sync_q & ~ext_prev_q;
	wire              step_end  = cur_ctl[CTL_LAST] ||
	                              ({1'b0, step_q} == (seq_depth(cur_q) - 4'h1));
	wire              storing   = (state_q == ST_STORE);

	logic [3:0]       trig, cand, grant, full, empty, push, pop, ris_set;
	logic [1:0]       pick;
	logic             pick_ok;
	logic [2:0]       best;
	logic [31:0]      rdata;

	always_comb begin
		for (int s = 0; s < SEQ_N; s++) begin
			trig[s]    = active_q[s] & (((nib({16'h0, emux_q}, 3'(s)) == TRIG_PROC) & pssi_set[s])
			           | (nib({16'h0, emux_q}, 3'(s)) == TRIG_ALWAYS)
			           | ((nib({16'h0, emux_q}, 3'(s)) != TRIG_PROC)
			           & (nib({16'h0, emux_q}, 3'(s)) != TRIG_ALWAYS) & ext_rise));
			full[s]    = (cnt_q[s] == seq_depth(2'(s)));
			empty[s]   = (cnt_q[s] == 4'h0);
			push[s]    = storing && (cur_q == 2'(s)) && !full[s];
			pop[s]     = pop_req && (a_seq == 2'(s)) && !empty[s];
			ris_set[s] = storing && (cur_q == 2'(s)) && cur_ctl[CTL_IE];
		end
	end

	// Lowest priority value wins; equal values fall back to the lower sequencer number
	always_comb begin
		cand    = pend_q & active_q;
		best    = 3'h4;
		pick    = 2'h0;
		pick_ok = 1'b0;
		for (int s = 0; s < SEQ_N; s++) begin
			if (cand[s] && ({1'b0, pri_q[s*4 +: 2]} < best)) begin
				best    = {1'b0, pri_q[s*4 +: 2]};
				pick    = 2'(s);
				pick_ok = 1'b1;
			end
		end
		grant = (state_q == ST_IDLE && pick_ok) ? (4'h1 << pick) : 4'h0;
	end

	always_comb begin
		rdata = RST_ZERO;
		case (addr_q)
			OFS_ACTIVE: rdata[3:0]  = active_q;
			OFS_RIS:    rdata[3:0]  = ris_q;
			OFS_IM:     rdata[3:0]  = im_q;
			OFS_ISC:    rdata[3:0]  = ris_q & im_q;
			OFS_OSTAT:  rdata[3:0]  = ostat_q;
			OFS_EMUX:   rdata[15:0] = emux_q;
			OFS_USTAT:  rdata[3:0]  = ustat_q;
			OFS_PRI:    rdata[15:0] = pri_q;
			OFS_SAC:    rdata[2:0]  = sac_q;
			OFS_LOOP:   rdata[0]    = loop_q;
			default: begin
				if (seq_hit) begin
					case (a_sub)
						SUB_MUX:   rdata = mux_q[a_seq];
						SUB_CTL:   rdata = ctl_q[a_seq];
						SUB_FIFO:  rdata[RES_W-1:0] = fifo_q[a_seq][tail_q[a_seq]];
						SUB_FSTAT: begin
							rdata[3:0]                   = {1'b0, tail_q[a_seq]};
							rdata[FSTAT_HEAD_LSB +: 4]   = {1'b0, head_q[a_seq]};
							rdata[FSTAT_EMPTY]           = empty[a_seq];
							rdata[FSTAT_FULL]            = full[a_seq];
						end
						default: rdata = RST_ZERO;
					endcase
				end
			end
		endcase
	end

	// Reads take one wait state so a read right after a write sees the new value
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wr_q     <= 1'b0;
			rd_q     <= 1'b0;
			addr_q   <= 12'h000;
			hready_q <= 1'b1;
			hrdata_q <= RST_ZERO;
		end else begin
			wr_q     <= addr_take & hwrite_i;
			rd_q     <= addr_take & ~hwrite_i;
			if (addr_take)
				addr_q <= haddr_i[11:0];
			hready_q <= !(addr_take & ~hwrite_i);
			if (rd_q)
				hrdata_q <= rdata;
		end
	end

	// Two-stage synchronisers for pins from the analog side
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			{done_meta_q, done_sync_q, done_prev_q} <= 3'h0;
			{ext_meta_q, ext_sync_q, ext_prev_q}    <= 3'h0;
			data_meta_q <= 10'h000;
			data_sync_q <= 10'h000;
		end else begin
			{done_meta_q, done_sync_q, done_prev_q} <= {conv_done_i, done_meta_q, done_sync_q};
			{ext_meta_q, ext_sync_q, ext_prev_q}    <= {ext_trigger_i, ext_meta_q, ext_sync_q};
			data_meta_q <= conv_data_i;
			data_sync_q <= data_meta_q;
		end
	end

	// Software registers; hardware set wins over a same-cycle write-1 clear
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			active_q <= 4'h0;
			im_q     <= 4'h0;
			emux_q   <= 16'h0000;
			pri_q    <= RST_PRI;
			sac_q    <= 3'h0;
			loop_q   <= 1'b0;
			ris_q    <= 4'h0;
			ostat_q  <= 4'h0;
			ustat_q  <= 4'h0;
			pend_q   <= 4'h0;
			for (int s = 0; s < SEQ_N; s++) begin
				mux_q[s] <= RST_ZERO;
				ctl_q[s] <= (s == SEQ_N - 1) ? RST_CTL3 : RST_ZERO;
			end
		end else begin
			if (wr_q) begin
				case (addr_q)
					OFS_ACTIVE: active_q <= hwdata_i[3:0];
					OFS_IM:     im_q     <= hwdata_i[3:0];
					OFS_EMUX:   emux_q   <= hwdata_i[15:0];
					OFS_PRI:    pri_q    <= hwdata_i[15:0] & RST_PRI | hwdata_i[15:0] & ~RST_PRI;
					OFS_SAC:    sac_q    <= hwdata_i[2:0];
					OFS_LOOP:   loop_q   <= hwdata_i[0];
					default: begin
						if (seq_hit && a_sub == SUB_MUX)
							mux_q[a_seq] <= hwdata_i;
						if (seq_hit && a_sub == SUB_CTL)
							ctl_q[a_seq] <= hwdata_i;
					end
				endcase
			end
			ris_q   <= (ris_q & ~(wr_isc ? hwdata_i[3:0] : 4'h0)) | ris_set;
			ostat_q <= (ostat_q & ~(wr_ostat ? hwdata_i[3:0] : 4'h0))
			         | ((storing && full[cur_q]) ? (4'h1 << cur_q) : 4'h0);
			ustat_q <= (ustat_q & ~(wr_ustat ? hwdata_i[3:0] : 4'h0))
			         | ((pop_req && empty[a_seq]) ? (4'h1 << a_seq) : 4'h0);
			pend_q  <= active_q & ((pend_q & ~grant) | trig);
		end
	end

	// Per-sequencer result FIFOs, circular with head for writes and tail for pops
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (int s = 0; s < SEQ_N; s++) begin
				head_q[s] <= 3'h0;
				tail_q[s] <= 3'h0;
				cnt_q[s]  <= 4'h0;
			end
		end else begin
			for (int s = 0; s < SEQ_N; s++) begin
				if (push[s]) begin
					fifo_q[s][head_q[s]] <= avg_res;
					head_q[s] <= ({1'b0, head_q[s]} == seq_depth(2'(s)) - 4'h1) ? 3'h0
					           : head_q[s] + 3'h1;
				end
				if (pop[s])
					tail_q[s] <= ({1'b0, tail_q[s]} == seq_depth(2'(s)) - 4'h1) ? 3'h0
					           : tail_q[s] + 3'h1;
				cnt_q[s] <= cnt_q[s] + 4'(push[s]) - 4'(pop[s]);
			end
		end
	end

	// Step engine: START issues one conversion, WAIT accumulates, STORE writes the FIFO
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_q    <= ST_IDLE;
			cur_q      <= 2'h0;
			step_q     <= 3'h0;
			rep_q      <= 7'h00;
			acc_q      <= 16'h0000;
			start_q    <= 1'b0;
			chan_q     <= 3'h0;
			diff_q     <= 1'b0;
			temp_q     <= 1'b0;
			loop_cnt_q <= 7'h00;
		end else begin
			start_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (pick_ok) begin
						cur_q   <= pick;
						step_q  <= 3'h0;
						state_q <= ST_START;
					end
				end
				ST_START: begin
					rep_q   <= 7'h00;
					acc_q   <= 16'h0000;
					diff_q  <= cur_ctl[CTL_DIFF];
					temp_q  <= cur_ctl[CTL_TEMP];
					// Pair k drives its even input as the positive side, odd one is implied
					chan_q  <= cur_ctl[CTL_DIFF] ? {cur_mux[1:0], 1'b0} : cur_mux[2:0];
					start_q <= !loop_q;
					state_q <= ST_WAIT;
				end
				ST_WAIT: begin
					if (conv_ev) begin
						acc_q <= acc_sum;
						if (loop_q)
							loop_cnt_q <= loop_cnt_q + 7'h01;
						if (rep_q == rep_last) begin
							state_q <= ST_STORE;
						end else begin
							rep_q   <= rep_q + 7'h01;
							start_q <= !loop_q;
						end
					end
				end
				ST_STORE: begin
					// Converter's differential code, 0x1FF at zero, is stored unaltered
					if (step_end) begin
						state_q <= ST_IDLE;
					end else begin
						step_q  <= step_q + 3'h1;
						state_q <= ST_START;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			irq_q <= 1'b0;
		else
			irq_q <= |(ris_q & im_q);
	end

	assign hrdata_o       = hrdata_q;
	assign hreadyout_o    = hready_q;
	assign hresp_o        = 1'b0 & hready_q;
	assign conv_start_o   = start_q;
	assign conv_channel_o = chan_q;
	assign conv_diff_o    = diff_q;
	assign conv_temp_o    = temp_q;
	assign irq_o          = irq_q;

endmodule

// ---- test/adc_conv_model.sv ----
// Behavioural converter core and input multiplexer facing the control block
`timescale 1ns/10ps
module adc_conv_model (
	input  wire logic       clk_i,   // Converter clock
	input  wire logic       start_i, // Start pulse
	input  wire logic [2:0] chan_i,  // Input, or even input of a pair
	input  wire logic       diff_i,  // Differential step
	output logic            done_o,  // Toggles once per result
	output logic [9:0]      data_o   // Result code
);
	logic [9:0] lvl [0:7];
	logic       slow_q = 1'b0;

	// Odd inputs sit at 0x100, a quarter of full scale, so pairs give negative, zero and positive differences
	initial begin
		done_o = 1'b0;
		data_o = 10'h2AA;
		for (int i = 0; i < 8; i++)
			lvl[i] = i[0] ? 10'h100 : 10'(10'h0C0 + i * 10'h020);
	end

	// Alternates prompt and slow answers
	task automatic convert(input logic [2:0] c, input logic d);
		repeat (slow_q ? 5 : 1) @(posedge clk_i);
		slow_q <= ~slow_q;
		data_o <= d ? 10'(511 + (int'(lvl[c]) - int'(lvl[c | 3'h1])) / 2) : lvl[c];
		@(posedge clk_i);
		done_o <= ~done_o;
	endtask

	always @(posedge clk_i) begin
		if (start_i === 1'b1)
			convert(chan_i, diff_i);
	end
endmodule

// ---- test/adc_ctrl_assertions.sv ----
// Port checker for the converter control block
`timescale 1ns/10ps
module adc_ctrl_checker (
	input wire logic        clk_i,          // Clock
	input wire logic        reset_n_i,      // Reset, active low
	input wire logic        hsel_i,         // Select
	input wire logic [1:0]  htrans_i,       // Transfer type
	input wire logic        hwrite_i,       // Write
	input wire logic        hready_i,       // Bus ready
	input wire logic [31:0] hrdata_o,       // Read data
	input wire logic        hreadyout_o,    // Slave ready
	input wire logic        hresp_o,        // Response
	input wire logic        conv_start_o,   // Start pulse
	input wire logic [2:0]  conv_channel_o, // Channel
	input wire logic        conv_diff_o,    // Differential
	input wire logic        irq_o           // Interrupt
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	wire req_rd = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
	wire req_wr = hsel_i & hready_i & htrans_i[1] & hwrite_i;

	chk_resp_okay: assert property (hresp_o == 1'b0)
		else $error("response not OKAY");
	chk_read_wait: assert property (req_rd |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	chk_write_nowait: assert property (req_wr |=> hreadyout_o)
		else $error("write stalled");
	chk_wait_cause: assert property ($fell(hreadyout_o) |-> $past(req_rd))
		else $error("wait without read");
	chk_rdata_stands: assert property ($changed(hrdata_o) |-> $past(hreadyout_o) == 1'b0)
		else $error("read data moved");
	chk_start_pulse: assert property (conv_start_o |=> !conv_start_o [*2])
		else $error("start pulse too long");
	chk_diff_even: assert property (conv_start_o && conv_diff_o |-> !conv_channel_o[0])
		else $error("odd channel on differential");
	chk_reset_quiet: assert property ($rose(reset_n_i) |-> hreadyout_o && !conv_start_o
		&& !irq_o && hrdata_o == 32'h0)
		else $error("outputs not idle after reset");
endmodule

// ---- test/tb_adc_average_diff_sequencer_setup.sv ----
// Testbench: register setup, differential steps, averaging, loopback
`timescale 1ns/10ps
module tb_adc_average_diff_sequencer_setup import adc_ctrl_pkg::*;;
	logic        clk_i = 1'b0, reset_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
	logic [1:0]  htrans_i = 2'h0;
	logic        hreadyout_o, hresp_o, conv_start_o, conv_diff_o, conv_temp_o, irq_o;
	logic        conv_done_i;
	logic        ext_trigger_i = 1'b0;
	logic [2:0]  conv_channel_o;
	logic [9:0]  conv_data_i;
	int          error_cnt = 0, checks_done = 0, starts = 0, s0;

	adc_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .ext_trigger_i(ext_trigger_i), .conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i), .conv_start_o(conv_start_o),
		.conv_channel_o(conv_channel_o), .conv_diff_o(conv_diff_o),
		.conv_temp_o(conv_temp_o), .irq_o(irq_o));

	adc_conv_model conv_u (.clk_i(clk_i), .start_i(conv_start_o), .chan_i(conv_channel_o),
		.diff_i(conv_diff_o), .done_o(conv_done_i), .data_o(conv_data_i));

	// Module clock runs from time zero, well before the first register access
	initial forever #25 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (conv_start_o === 1'b1)
			starts++;
	end

	task automatic end_sim;
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// Address phase held until ready, then data phase held until ready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
		hsel_i <= 1'b1;
		haddr_i <= {20'h0, a};
		hwrite_i <= w;
		htrans_i <= 2'h2;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
		xfer(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask

	task automatic wait_irq;
		for (int i = 0; i < 3000 && irq_o !== 1'b1; i++)
			@(posedge clk_i);
		chk("irq", 32'h1, {31'h0, irq_o});
	endtask

	initial begin
		repeat (40000) @(posedge clk_i);
		error_cnt++;
		end_sim;
	end

	initial begin
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		rdchk(OFS_PRI, 32'h3210, "priority");
		rdchk(OFS_SAC, 32'h0, "averaging");
		rdchk(12'h0A4, 32'h2, "control 3");
		rdchk(12'h04C, 32'h100, "fifo 0 status");
		rdchk(12'h0FC, 32'h0, "unmapped");
		wr(OFS_EMUX, 32'h0);
		wr(12'h040, 32'h316);
		wr(12'h044, 32'h710);
		wr(OFS_PSSI, 32'h1);
		repeat (20) @(posedge clk_i);
		rdchk(12'h04C, 32'h100, "disabled fifo 0");
		wr(OFS_IM, 32'h1);
		s0 = starts;
		wr(OFS_ACTIVE, 32'h1);
		wr(OFS_PSSI, 32'h1);
		wait_irq;
		chk("starts", 32'h3, 32'(starts - s0));
		rdchk(OFS_RIS, 32'h1, "raw status");
		rdchk(12'h048, 32'h180, "single step");
		rdchk(12'h048, 32'h1FF, "diff zero");
		rdchk(12'h048, 32'h23F, "diff positive");
		wr(OFS_ISC, 32'h1);
		rdchk(OFS_RIS, 32'h0, "cleared status");
		chk("irq low", 32'h0, {31'h0, irq_o});
		// Sixty-four differential samples on pair 0 of sequencer 3
		wr(OFS_ACTIVE, 32'h0);
		wr(12'h0A0, 32'h0);
		wr(12'h0A4, 32'h7);
		wr(OFS_IM, 32'h8);
		wr(OFS_SAC, 32'h6);
		s0 = starts;
		wr(OFS_ACTIVE, 32'h8);
		wr(OFS_PSSI, 32'h8);
		wait_irq;
		chk("avg starts", 32'h40, 32'(starts - s0));
		rdchk(12'h0A8, 32'h1DF, "avg diff");
		rdchk(12'h0AC, 32'h100, "fifo 3 empty");
		wr(OFS_ACTIVE, 32'h0);
		wr(OFS_SAC, 32'h0);
		wr(OFS_ISC, 32'h8);
		wr(OFS_LOOP, 32'h1);
		s0 = starts;
		wr(OFS_ACTIVE, 32'h8);
		wr(OFS_PSSI, 32'h8);
		wait_irq;
		xfer(1'b0, 12'h0A8, 32'h0);
		chk("loop word", 32'h0, rd & 32'hFFFF_FC07);
		chk("loop starts", 32'h0, 32'(starts - s0));
		// External pin trigger on sequencer 3, pair 2 with the temperature bit set
		wr(OFS_ACTIVE, 32'h0);
		wr(OFS_LOOP, 32'h0);
		wr(OFS_ISC, 32'h8);
		wr(OFS_EMUX, 32'h4000);
		wr(12'h0A0, 32'h2);
		wr(12'h0A4, 32'hF);
		s0 = starts;
		wr(OFS_ACTIVE, 32'h8);
		ext_trigger_i <= 1'b1;
		wait_irq;
		chk("ext starts", 32'h1, 32'(starts - s0));
		chk("temp select", 32'h1, {31'h0, conv_temp_o});
		rdchk(12'h0A8, 32'h21F, "diff pair 2");
		// Popping the now empty FIFO returns the stale entry and flags underflow
		rdchk(12'h0A8, 32'h21F, "stale pop");
		rdchk(OFS_USTAT, 32'h8, "underflow");
		ext_trigger_i <= 1'b0;
		end_sim;
	end
endmodule

bind adc_ctrl adc_ctrl_checker chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .conv_start_o(conv_start_o),
	.conv_channel_o(conv_channel_o), .conv_diff_o(conv_diff_o), .irq_o(irq_o));
